// ### rtl/prx_dev.sv
// Sensor end: proximity readout, limits, emitter setup, interrupt
//
// Summary of operation
// R1: Proximity result readable as 8-bit value
// R2: Interrupt above upper limit after count reached
// R3: Interrupt below lower limit after count reached
// R4: Persistence code 00..11 means 1..4 conversions
// R5: Upper nibble multiplies base emitter current
// R6: Lower nibble selects infrared or green; host gates
// R7: Offset run stores measured offset automatically
// R8: Host writes offset and trim at first use
// R9: Host reruns offset after pulse/current change
// R10: Host rewrites calibration; device corrects ambient data
// R11: Host computes lux from ratio, gain, factors
// R12: Host discards all-ones auto-scale reading
// R13: Host discards 2^n-1 readings at high gain
// R14: Host avoids highest auto-scale gain when possible
// R15: Counter clears when conversion returns in range
`timescale 1ns/1ps
`default_nettype none
module prx_dev (
   input wire logic clk,
   input wire logic sys_rst,
   prx_link_if.dev link,
   input wire logic prox_enable,
   input wire logic prox_valid,
   input wire logic [7:0] prox_data,
   input wire logic uv_valid,
   input wire logic [7:0] uv_data,
   input wire logic offset_valid,
   input wire logic [7:0] offset_data,
   input wire logic als_valid,
   input wire logic [15:0] als_raw,
   output logic offset_run,
   output logic [2:0] pulse_time_code,
   output logic [9:0] drive_half_ma,
   output logic emitter_green,
   output logic [7:0] offset_value,
   output logic [7:0] pulse_trim,
   output logic [15:0] als_corr,
   output logic als_corr_valid,
   output logic irq
);
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] result_r, result_nxt;
   logic [7:0] upper_r, upper_nxt;
   logic [7:0] lower_r, lower_nxt;
   logic [7:0] source_r, source_nxt;
   logic [7:0] uv_r, uv_nxt;
   logic [7:0] amb_r, amb_nxt;
   logic [7:0] cal_r, cal_nxt;
   logic [7:0] offset_r, offset_nxt;
   logic [7:0] trim_r, trim_nxt;
   logic [1:0] stat_r, stat_nxt;
   logic [1:0] mask_r, mask_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [15:0] corr_r, corr_nxt;
   logic corr_vld_r, corr_vld_nxt;
   logic [9:0] drive_r, drive_nxt;
   logic green_r, green_nxt;
   logic high_evt, low_evt;
   logic [1:0] evt;
   logic [1:0] clr;
   logic [23:0] prod;

   // Base current in 0.5 mA steps
   function automatic logic [9:0] base_half_ma(input logic [1:0] code);
      case (code)
         2'h0: base_half_ma = 10'h005;
         2'h1: base_half_ma = 10'h00a;
         2'h2: base_half_ma = 10'h014;
         default: base_half_ma = 10'h01e;
      endcase
   endfunction

   // Current multiplier, unknown codes act as x1
   function automatic logic [9:0] mult(input logic [3:0] code);
      case (code)
         prx_pkg::MULT_X2: mult = 10'h002;
         prx_pkg::MULT_X10: mult = 10'h00a;
         prx_pkg::MULT_X20: mult = 10'h014;
         default: mult = 10'h001;
      endcase
   endfunction

   prx_persist #(
      .W(8)
   ) u_persist (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_valid(prox_valid),
      .sample(prox_data),
      .upper(upper_r),
      .lower(lower_r),
      .setting(ctrl_r[prx_pkg::CTRL_PRST_LSB +: 2]),
      .high_evt(high_evt),
      .low_evt(low_evt)
   );

   always_comb begin
      ctrl_nxt = ctrl_r;
      upper_nxt = upper_r;
      lower_nxt = lower_r;
      source_nxt = source_r;
      amb_nxt = amb_r;
      cal_nxt = cal_r;
      offset_nxt = offset_r;
      trim_nxt = trim_r;
      mask_nxt = mask_r;
      clr = 2'h0;
      if (link.wr) begin
         case (link.addr)
            prx_pkg::ADDR_CTRL: ctrl_nxt = link.wdata;
            prx_pkg::ADDR_UPPER: upper_nxt = link.wdata;
            prx_pkg::ADDR_LOWER: lower_nxt = link.wdata;
            prx_pkg::ADDR_SOURCE: source_nxt = link.wdata;
            prx_pkg::ADDR_AMB: amb_nxt = link.wdata;
            prx_pkg::ADDR_CAL: cal_nxt = link.wdata;
            prx_pkg::ADDR_OFFSET: offset_nxt = link.wdata;
            prx_pkg::ADDR_TRIM: trim_nxt = link.wdata;
            prx_pkg::ADDR_IRQ_STAT: clr = link.wdata[1:0];
            prx_pkg::ADDR_IRQ_MASK: mask_nxt = link.wdata[1:0];
            default: clr = 2'h0;
         endcase
      end
      // Finished offset run overrides a same-cycle write
      if (offset_valid && ctrl_r[prx_pkg::CTRL_TRIG_BIT] && prox_enable) begin
         offset_nxt = offset_data; // R7
         ctrl_nxt[prx_pkg::CTRL_TRIG_BIT] = 1'b0;
      end
      result_nxt = prox_valid ? prox_data : result_r; // R1
      uv_nxt = uv_valid ? uv_data : uv_r;
      evt = 2'h0;
      evt[prx_pkg::IRQ_HIGH_BIT] = high_evt; // R2
      evt[prx_pkg::IRQ_LOW_BIT] = low_evt; // R3
      stat_nxt = (stat_r & ~clr) | evt;
      // Ambient correction by calibration value
      prod = {8'h00, als_raw} * {16'h0000, cal_r};
      if (prod[23:prx_pkg::CAL_SHIFT+16] != '0) begin
         corr_nxt = 16'hffff; // R10
      end else begin
         corr_nxt = prod[prx_pkg::CAL_SHIFT +: 16]; // R10
      end
      if (!als_valid) begin
         corr_nxt = corr_r;
      end
      corr_vld_nxt = als_valid;
      drive_nxt = base_half_ma(ctrl_r[prx_pkg::CTRL_CUR_LSB +: 2])
         * mult(source_r[7:4]); // R5
      green_nxt = source_r[3:0] == prx_pkg::TYPE_GREEN; // R6
      rdata_nxt = 8'h00;
      if (link.rd) begin
         case (link.addr)
            prx_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
            prx_pkg::ADDR_RESULT: rdata_nxt = result_r; // R1
            prx_pkg::ADDR_UPPER: rdata_nxt = upper_r;
            prx_pkg::ADDR_LOWER: rdata_nxt = lower_r;
            prx_pkg::ADDR_SOURCE: rdata_nxt = source_r;
            prx_pkg::ADDR_UV: rdata_nxt = uv_r;
            prx_pkg::ADDR_AMB: rdata_nxt = amb_r;
            prx_pkg::ADDR_CAL: rdata_nxt = cal_r;
            prx_pkg::ADDR_OFFSET: rdata_nxt = offset_r;
            prx_pkg::ADDR_TRIM: rdata_nxt = trim_r;
            prx_pkg::ADDR_IRQ_STAT: rdata_nxt = {6'h00, stat_r};
            prx_pkg::ADDR_IRQ_MASK: rdata_nxt = {6'h00, mask_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_r <= prx_pkg::RST_CTRL;
         result_r <= prx_pkg::RST_ZERO;
         upper_r <= prx_pkg::RST_UPPER;
         lower_r <= prx_pkg::RST_LOWER;
         source_r <= prx_pkg::RST_SOURCE;
         uv_r <= prx_pkg::RST_ZERO;
         amb_r <= prx_pkg::RST_ZERO;
         cal_r <= prx_pkg::RST_CAL;
         offset_r <= prx_pkg::RST_ZERO;
         trim_r <= prx_pkg::RST_ZERO;
         stat_r <= 2'h0;
         mask_r <= 2'h0;
         rdata_r <= 8'h00;
         corr_r <= 16'h0000;
         corr_vld_r <= 1'b0;
         drive_r <= 10'h000;
         green_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         result_r <= result_nxt;
         upper_r <= upper_nxt;
         lower_r <= lower_nxt;
         source_r <= source_nxt;
         uv_r <= uv_nxt;
         amb_r <= amb_nxt;
         cal_r <= cal_nxt;
         offset_r <= offset_nxt;
         trim_r <= trim_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         corr_r <= corr_nxt;
         corr_vld_r <= corr_vld_nxt;
         drive_r <= drive_nxt;
         green_r <= green_nxt;
      end
   end

   assign link.rdata = rdata_r;
   assign irq = |(stat_r & mask_r); // R2
   assign link.int_n = ~(|(stat_r & mask_r)); // R3
   assign offset_run = ctrl_r[prx_pkg::CTRL_TRIG_BIT] && prox_enable; // R7
   assign pulse_time_code = ctrl_r[prx_pkg::CTRL_PT_LSB +: 3];
   assign drive_half_ma = drive_r;
   assign emitter_green = green_r;
   assign offset_value = offset_r;
   assign pulse_trim = trim_r;
   assign als_corr = corr_r;
   assign als_corr_valid = corr_vld_r;
endmodule
`default_nettype wire

// ### rtl/prx_host.sv
// Host end: init sequence, guarded register access, lux computation
`timescale 1ns/1ps
`default_nettype none
module prx_host #(
   parameter logic [7:0] INIT_OFFSET = 8'h1c,
   parameter logic [7:0] INIT_TRIM = 8'h1d,
   parameter logic [7:0] INIT_CAL = 8'h80
) (
   input wire logic clk,
   input wire logic sys_rst,
   prx_link_if.host link,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] cmd_rdata,
   output logic busy,
   output logic irq_seen,
   input wire logic lux_valid,
   input wire logic [15:0] lux_raw,
   input wire logic [1:0] lux_gain,
   input wire logic [7:0] lux_high_coef,
   output logic [39:0] lux_x100,
   output logic lux_out_valid,
   output logic lux_discard,
   output logic gain_advise
);
   typedef enum logic [4:0] {
      PRXH_OFFSET = 5'b00001,
      PRXH_TRIM = 5'b00010,
      PRXH_CAL = 5'b00100,
      PRXH_TRIG = 5'b01000,
      PRXH_RUN = 5'b10000
   } prxh_state_t;

   prxh_state_t st_r, st_nxt;
   logic [7:0] ctrl_sh_r, ctrl_sh_nxt;
   logic [7:0] amb_sh_r, amb_sh_nxt;
   logic [39:0] lux_r, lux_nxt;
   logic lux_vld_r, lux_vld_nxt;
   logic disc_r, disc_nxt;
   logic adv_r, adv_nxt;
   logic [39:0] t;
   logic [15:0] raw_p1;

   always_comb begin
      st_nxt = st_r;
      ctrl_sh_nxt = ctrl_sh_r;
      amb_sh_nxt = amb_sh_r;
      link.addr = cmd_addr;
      link.wdata = cmd_wdata;
      link.wr = 1'b0;
      link.rd = 1'b0;
      case (st_r)
         PRXH_OFFSET: begin
            link.addr = prx_pkg::ADDR_OFFSET; // R8
            link.wdata = INIT_OFFSET;
            link.wr = 1'b1;
            st_nxt = PRXH_TRIM;
         end
         PRXH_TRIM: begin
            link.addr = prx_pkg::ADDR_TRIM; // R8
            link.wdata = INIT_TRIM;
            link.wr = 1'b1;
            st_nxt = PRXH_CAL;
         end
         PRXH_CAL: begin
            link.addr = prx_pkg::ADDR_CAL; // R10
            link.wdata = INIT_CAL;
            link.wr = 1'b1;
            st_nxt = PRXH_TRIG;
         end
         PRXH_TRIG: begin
            link.addr = prx_pkg::ADDR_CTRL; // R9
            link.wdata = ctrl_sh_r | 8'h80;
            link.wr = 1'b1;
            st_nxt = PRXH_RUN;
         end
         PRXH_RUN: begin
            link.wr = cmd_wr;
            link.rd = cmd_rd;
            if (cmd_wr && cmd_addr == prx_pkg::ADDR_CTRL) begin
               ctrl_sh_nxt = cmd_wdata & 8'h7f;
               if (cmd_wdata[6:2] != ctrl_sh_r[6:2]) begin
                  link.wdata = cmd_wdata | 8'h80; // R9
               end
            end
            if (cmd_wr && cmd_addr == prx_pkg::ADDR_AMB) begin
               amb_sh_nxt = cmd_wdata;
            end
            if (cmd_wr && cmd_addr == prx_pkg::ADDR_SOURCE &&
                  cmd_wdata[3:0] == prx_pkg::TYPE_GREEN &&
                  !amb_sh_r[prx_pkg::AMB_LOW_BIT]) begin
               link.wdata = {cmd_wdata[7:4], prx_pkg::TYPE_IR}; // R6
            end
         end
         default: st_nxt = PRXH_OFFSET;
      endcase
      // Lux in hundredths
      t = ({24'h000000, lux_raw} * prx_pkg::LUX_RATIO_X100) >> lux_gain;
      if (amb_sh_r[prx_pkg::AMB_HIGH_BIT]) begin
         t = t * ({32'h0, lux_high_coef} * prx_pkg::HIGH_MULT + 40'h1)
            / ({32'h0, lux_high_coef} + 40'h1); // R11
      end
      if (amb_sh_r[prx_pkg::AMB_LOW_BIT]) begin
         t = t / prx_pkg::LOW_FACTOR; // R11
      end
      raw_p1 = lux_raw + 16'h0001;
      disc_nxt = disc_r;
      lux_nxt = lux_r;
      adv_nxt = adv_r;
      if (lux_valid) begin
         disc_nxt = (lux_raw == prx_pkg::DISCARD_ALL) || // R12
            (lux_gain >= prx_pkg::GAIN_X4 &&
            lux_raw >= prx_pkg::DISCARD_MIN &&
            (lux_raw & raw_p1) == 16'h0000); // R13
         lux_nxt = t;
         adv_nxt = lux_gain == prx_pkg::GAIN_X8; // R14
      end
      lux_vld_nxt = lux_valid;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r <= PRXH_OFFSET;
         ctrl_sh_r <= prx_pkg::RST_CTRL;
         amb_sh_r <= prx_pkg::RST_ZERO;
         lux_r <= 40'h0;
         lux_vld_r <= 1'b0;
         disc_r <= 1'b0;
         adv_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         ctrl_sh_r <= ctrl_sh_nxt;
         amb_sh_r <= amb_sh_nxt;
         lux_r <= lux_nxt;
         lux_vld_r <= lux_vld_nxt;
         disc_r <= disc_nxt;
         adv_r <= adv_nxt;
      end
   end

   assign cmd_rdata = link.rdata;
   assign busy = st_r != PRXH_RUN;
   assign irq_seen = ~link.int_n;
   assign lux_x100 = lux_r;
   assign lux_out_valid = lux_vld_r;
   assign lux_discard = disc_r;
   assign gain_advise = adv_r;
endmodule
`default_nettype wire

// ### rtl/prx_link_if.sv
// Register link between host controller and sensor device
`timescale 1ns/1ps
`default_nettype none
interface prx_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic int_n;
   modport dev (input addr, input wdata, input wr, input rd,
      output rdata, output int_n);
   modport host (output addr, output wdata, output wr, output rd,
      input rdata, input int_n);
endinterface
`default_nettype wire

// ### rtl/prx_persist.sv
// Threshold compare with consecutive-count filter
`timescale 1ns/1ps
`default_nettype none
module prx_persist #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sample_valid,
   input wire logic [W-1:0] sample,
   input wire logic [W-1:0] upper,
   input wire logic [W-1:0] lower,
   input wire logic [1:0] setting,
   output logic high_evt,
   output logic low_evt
);
   logic [2:0] cnt_r, cnt_nxt;
   logic dir_r, dir_nxt;
   logic high_r, high_nxt;
   logic low_r, low_nxt;
   logic above, below, hit;
   logic [2:0] need;

   always_comb begin
      above = sample > upper;
      below = sample < lower;
      need = {1'b0, setting} + 3'h1;
      cnt_nxt = cnt_r;
      dir_nxt = dir_r;
      hit = 1'b0;
      if (sample_valid) begin
         if (!above && !below) begin
            cnt_nxt = 3'h0; // R15
         end else if (cnt_r == 3'h0 || above != dir_r) begin
            cnt_nxt = 3'h1;
            dir_nxt = above;
            hit = need == 3'h1; // R4
         end else if (cnt_r < need) begin
            cnt_nxt = cnt_r + 3'h1;
            hit = cnt_nxt == need; // R4
         end
      end
      high_nxt = hit && above; // R2
      low_nxt = hit && below; // R3
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_r <= 3'h0;
         dir_r <= 1'b0;
         high_r <= 1'b0;
         low_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         dir_r <= dir_nxt;
         high_r <= high_nxt;
         low_r <= low_nxt;
      end
   end

   assign high_evt = high_r;
   assign low_evt = low_r;
endmodule
`default_nettype wire

// ### rtl/prx_pkg.sv
// Constants shared by both ends of the proximity readout link
package prx_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h09;
   localparam logic [7:0] ADDR_RESULT = 8'h0a;
   localparam logic [7:0] ADDR_UPPER = 8'h0b;
   localparam logic [7:0] ADDR_LOWER = 8'h0c;
   localparam logic [7:0] ADDR_SOURCE = 8'h0d;
   localparam logic [7:0] ADDR_UV = 8'h0e;
   localparam logic [7:0] ADDR_AMB = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h21;
   localparam logic [7:0] ADDR_CAL = 8'ha2;
   localparam logic [7:0] ADDR_OFFSET = 8'ha5;
   localparam logic [7:0] ADDR_TRIM = 8'ha6;
   // Field positions
   localparam int CTRL_TRIG_BIT = 7;
   localparam int CTRL_PT_LSB = 4;
   localparam int CTRL_CUR_LSB = 2;
   localparam int CTRL_PRST_LSB = 0;
   localparam int AMB_LOW_BIT = 5;
   localparam int AMB_HIGH_BIT = 3;
   localparam int IRQ_HIGH_BIT = 0;
   localparam int IRQ_LOW_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_UPPER = 8'hff;
   localparam logic [7:0] RST_LOWER = 8'h00;
   localparam logic [7:0] RST_SOURCE = 8'h00;
   localparam logic [7:0] RST_CAL = 8'h80;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Emitter source codes
   localparam logic [3:0] MULT_X2 = 4'h8;
   localparam logic [3:0] MULT_X10 = 4'h5;
   localparam logic [3:0] MULT_X20 = 4'hd;
   localparam logic [3:0] TYPE_IR = 4'h0;
   localparam logic [3:0] TYPE_GREEN = 4'h5;
   // Calibration unity shift
   localparam int CAL_SHIFT = 7;
   // Lux arithmetic
   localparam logic [39:0] LUX_RATIO_X100 = 40'h0d;
   localparam logic [39:0] LOW_FACTOR = 40'h2a;
   localparam logic [39:0] HIGH_MULT = 40'h40;
   localparam logic [15:0] DISCARD_ALL = 16'hffff;
   localparam logic [15:0] DISCARD_MIN = 16'h01ff;
   localparam logic [1:0] GAIN_X4 = 2'h2;
   localparam logic [1:0] GAIN_X8 = 2'h3;
endpackage

// ### tb/prx_monitor.sv
// Assertion checker on the link between host and device
`timescale 1ns/1ps
`default_nettype none
module prx_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic int_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence seq_wr(logic [7:0] a);
      wr && addr == a;
   endsequence

   sequence seq_rd(logic [7:0] a);
      rd && addr == a;
   endsequence

   property echo(logic [7:0] a);
      seq_wr(a) ##1 seq_rd(a) |=> rdata == $past(wdata, 2);
   endproperty

   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside read slot");
   chk_upper_echo: assert property (echo(prx_pkg::ADDR_UPPER))
      else $error("upper limit readback differs");
   chk_lower_echo: assert property (echo(prx_pkg::ADDR_LOWER))
      else $error("lower limit readback differs");
   chk_source_echo: assert property (echo(prx_pkg::ADDR_SOURCE))
      else $error("source select readback differs");
   chk_cal_echo: assert property (echo(prx_pkg::ADDR_CAL))
      else $error("calibration readback differs");
   chk_offset_echo: assert property (echo(prx_pkg::ADDR_OFFSET))
      else $error("offset readback differs");
   chk_mask_off: assert property (seq_wr(prx_pkg::ADDR_IRQ_MASK)
      ##0 wdata == 8'h00 |=> int_n)
      else $error("interrupt active with mask cleared");
   chk_stat_set: assert property (!int_n ##0 seq_rd(prx_pkg::ADDR_IRQ_STAT)
      |=> rdata[1:0] != 2'h0)
      else $error("interrupt active with empty status");
   chk_int_release: assert property ($rose(int_n) |-> $past(wr) &&
      ($past(addr) == prx_pkg::ADDR_IRQ_STAT ||
      $past(addr) == prx_pkg::ADDR_IRQ_MASK))
      else $error("interrupt released without clear or mask");
endmodule
`default_nettype wire

// ### tb/prx_test.sv
// Bench for both ends of the proximity readout link
`timescale 1ns/1ps
`default_nettype none
module prx_test;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic prox_valid = 1'b0;
   logic [7:0] prox_data = 8'h00;
   logic offset_valid = 1'b0;
   logic [7:0] offset_data = 8'h00;
   logic als_valid = 1'b0;
   logic [15:0] als_raw = 16'h0000;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_wr = 1'b0;
   logic cmd_rd = 1'b0;
   logic lux_valid = 1'b0;
   logic [15:0] lux_raw = 16'h0000;
   logic [1:0] lux_gain = 2'h0;
   logic [7:0] lux_coef = 8'h00;
   logic prox_enable = 1'b1;
   logic [7:0] cmd_rdata;
   logic [7:0] offset_value, pulse_trim;
   logic [2:0] pulse_time_code;
   logic offset_run;
   logic [9:0] drive_half_ma;
   logic [15:0] als_corr;
   logic [39:0] lux_x100;
   logic emitter_green, als_corr_valid, irq, busy, irq_seen;
   logic lux_out_valid, lux_discard, gain_advise;
   logic [3:0] mcode [4] = '{4'h0, 4'h8, 4'h5, 4'hd};
   int mmul [4] = '{1, 2, 10, 20};
   int bad_count = 0;
   int comparisons = 0;
   int i, p;

   prx_link_if link ();
   prx_dev u_prx_dev (.clk(clk), .sys_rst(sys_rst), .link(link),
      .prox_enable(prox_enable), .prox_valid(prox_valid),
      .prox_data(prox_data), .uv_valid(prox_valid), .uv_data(prox_data),
      .offset_valid(offset_valid),
      .offset_data(offset_data), .als_valid(als_valid), .als_raw(als_raw),
      .offset_run(offset_run), .pulse_time_code(pulse_time_code),
      .drive_half_ma(drive_half_ma),
      .emitter_green(emitter_green), .offset_value(offset_value),
      .pulse_trim(pulse_trim),
      .als_corr(als_corr), .als_corr_valid(als_corr_valid), .irq(irq));
   prx_host u_prx_host (.clk(clk), .sys_rst(sys_rst), .link(link),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .busy(busy),
      .irq_seen(irq_seen), .lux_valid(lux_valid), .lux_raw(lux_raw),
      .lux_gain(lux_gain), .lux_high_coef(lux_coef), .lux_x100(lux_x100),
      .lux_out_valid(lux_out_valid), .lux_discard(lux_discard),
      .gain_advise(gain_advise));
   prx_monitor u_prx_monitor (.clk(clk), .sys_rst(sys_rst),
      .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
      .rdata(link.rdata), .int_n(link.int_n));

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      cmd_wr <= 1'b1;
      cmd_rd <= 1'b0;
      cmd_addr <= a;
      cmd_wdata <= d;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      cmd_wr <= 1'b0;
      cmd_rd <= 1'b1;
      cmd_addr <= a;
      @(posedge clk);
      cmd_rd <= 1'b0;
      #1 chk(cmd_rdata, e);
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         cmd_wr <= 1'b0;
         cmd_rd <= 1'b0;
      end
   endtask

   task automatic prox(input logic [7:0] d);
      @(posedge clk);
      cmd_wr <= 1'b0;
      prox_valid <= 1'b1;
      prox_data <= d;
      @(posedge clk);
      prox_valid <= 1'b0;
      tick(2);
   endtask

   task automatic lux(input logic [15:0] r, input logic [1:0] g,
      input logic [39:0] e, input logic dis, input logic adv);
      @(posedge clk);
      cmd_wr <= 1'b0;
      lux_valid <= 1'b1;
      lux_raw <= r;
      lux_gain <= g;
      @(posedge clk);
      lux_valid <= 1'b0;
      #1 chk(lux_out_valid, 1'b1);
      chk(lux_x100, e);
      chk(lux_discard, dis);
      chk(gain_advise, adv);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      forever #5 clk = ~clk;
   end

   initial begin
      #200000;
      bad_count++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      tick(2);
      for (i = 0; i < 20 && busy !== 1'b0; i++) tick(1);
      chk(busy, 1'b0);
      rd(prx_pkg::ADDR_OFFSET, 8'h1c);
      rd(prx_pkg::ADDR_TRIM, 8'h1d);
      rd(prx_pkg::ADDR_CAL, 8'h80);
      rd(prx_pkg::ADDR_CTRL, 8'h80);
      chk(offset_run, 1'b1);
      chk(pulse_trim, 8'h1d);
      rd(prx_pkg::ADDR_SOURCE, 8'h00);
      rd(8'h3f, 8'h00);
      @(posedge clk);
      prox_enable <= 1'b0;
      offset_valid <= 1'b1;
      offset_data <= 8'h44;
      @(posedge clk);
      prox_enable <= 1'b1;
      offset_data <= 8'h33;
      @(posedge clk);
      offset_valid <= 1'b0;
      rd(prx_pkg::ADDR_OFFSET, 8'h33);
      chk(offset_value, 8'h33);
      rd(prx_pkg::ADDR_CTRL, 8'h00);
      chk(offset_run, 1'b0);
      wr(prx_pkg::ADDR_OFFSET, 8'h1c);
      rd(prx_pkg::ADDR_OFFSET, 8'h1c);
      $display("test reset and offset done");
      wr(prx_pkg::ADDR_UPPER, 8'h80);
      rd(prx_pkg::ADDR_UPPER, 8'h80);
      wr(prx_pkg::ADDR_LOWER, 8'h20);
      rd(prx_pkg::ADDR_LOWER, 8'h20);
      wr(prx_pkg::ADDR_IRQ_MASK, 8'h03);
      for (p = 0; p < 4; p++) begin
         wr(prx_pkg::ADDR_CTRL, 8'(p));
         prox(8'h50);
         repeat (p) prox(8'h90);
         rd(prx_pkg::ADDR_IRQ_STAT, 8'h00);
         prox(8'h50);
         repeat (p) prox(8'h90);
         rd(prx_pkg::ADDR_IRQ_STAT, 8'h00);
         prox(8'h90);
         #1 chk(irq_seen, 1'b1);
         rd(prx_pkg::ADDR_IRQ_STAT, 8'h01);
         wr(prx_pkg::ADDR_IRQ_STAT, 8'h01);
         rd(prx_pkg::ADDR_IRQ_STAT, 8'h00);
      end
      wr(prx_pkg::ADDR_CTRL, 8'h00);
      wr(prx_pkg::ADDR_IRQ_MASK, 8'h00);
      prox(8'h10);
      #1 chk(irq_seen, 1'b0);
      rd(prx_pkg::ADDR_IRQ_STAT, 8'h02);
      rd(prx_pkg::ADDR_RESULT, 8'h10);
      rd(prx_pkg::ADDR_UV, 8'h10);
      wr(prx_pkg::ADDR_RESULT, 8'h00);
      rd(prx_pkg::ADDR_RESULT, 8'h10);
      wr(prx_pkg::ADDR_IRQ_MASK, 8'h03);
      tick(1);
      #1 chk(irq, 1'b1);
      wr(prx_pkg::ADDR_IRQ_STAT, 8'h03);
      rd(prx_pkg::ADDR_IRQ_STAT, 8'h00);
      $display("test thresholds done");
      wr(prx_pkg::ADDR_CTRL, 8'h14);
      rd(prx_pkg::ADDR_CTRL, 8'h94);
      chk(pulse_time_code, 3'h1);
      for (i = 0; i < 4; i++) begin
         wr(prx_pkg::ADDR_SOURCE, {mcode[i], 4'h0});
         tick(2);
         #1 chk(drive_half_ma, 10'(10 * mmul[i]));
      end
      wr(prx_pkg::ADDR_SOURCE, 8'h05);
      rd(prx_pkg::ADDR_SOURCE, 8'h00);
      wr(prx_pkg::ADDR_AMB, 8'h20);
      wr(prx_pkg::ADDR_SOURCE, 8'h05);
      rd(prx_pkg::ADDR_SOURCE, 8'h05);
      tick(1);
      #1 chk(emitter_green, 1'b1);
      $display("test emitter done");
      wr(prx_pkg::ADDR_CAL, 8'h40);
      rd(prx_pkg::ADDR_CAL, 8'h40);
      @(posedge clk);
      als_valid <= 1'b1;
      als_raw <= 16'h1000;
      @(posedge clk);
      als_valid <= 1'b0;
      #1 chk(als_corr_valid, 1'b1);
      chk(als_corr, 16'h0800);
      lux(16'h5678, 2'h1, 40'hd61, 1'b0, 1'b0);
      lux(16'h01ff, 2'h2, 40'h27, 1'b1, 1'b0);
      lux(16'h01ff, 2'h1, 40'h4f, 1'b0, 1'b0);
      lux(16'hffff, 2'h0, 40'h4f3c, 1'b1, 1'b0);
      lux(16'h0064, 2'h3, 40'h3, 1'b0, 1'b1);
      wr(prx_pkg::ADDR_AMB, 8'h08);
      lux_coef <= 8'h0a;
      lux(16'h1234, 2'h0, 40'h35ddb1, 1'b0, 1'b0);
      $display("test ambient and lux done");
      end_of_test();
   end
endmodule
`default_nettype wire
